/* File: inc/pifr_pkg.sv */
package pifr_pkg;

  // Coprocessor number and fixed opcode fields of this register bank.
  localparam logic [3:0] PIFR_CP_NUM = 4'hf;
  localparam logic [2:0] PIFR_OPC1 = 3'h0;
  localparam logic [3:0] PIFR_CRN = 4'h0;
  localparam logic [3:0] PIFR_CRM_ID = 4'h0;
  localparam logic [3:0] PIFR_CRM_FEAT = 4'h1;

  // Second opcode values within the identification group.
  localparam logic [2:0] PIFR_OPC2_TIGHT = 3'h2;
  localparam logic [2:0] PIFR_OPC2_TLB = 3'h3;
  localparam logic [2:0] PIFR_OPC2_AFF = 3'h5;

  // Second opcode values within the feature group.
  localparam logic [2:0] PIFR_OPC2_PF0 = 3'h0;
  localparam logic [2:0] PIFR_OPC2_PF1 = 3'h1;
  localparam logic [2:0] PIFR_OPC2_DBG = 3'h2;
  localparam logic [2:0] PIFR_OPC2_AUX = 3'h3;

  // Affinity layout.
  localparam int PIFR_AFF_FMT_BIT = 31;
  localparam int PIFR_AFF_UNI_BIT = 30;
  localparam int PIFR_AFF_CLU_LSB = 8;
  localparam int PIFR_CLU_W = 4;
  localparam logic [1:0] PIFR_CORE_NUMBER = 2'h0;

  // Feature register contents.
  localparam logic [31:0] PIFR_PF0_VAL = 32'h0000_1231;
  localparam logic [31:0] PIFR_PF1_VAL = 32'h0000_0011;
  localparam logic [31:0] PIFR_DBG_VAL = 32'h0201_0444;
  localparam logic [31:0] PIFR_AUX_VAL = 32'h0000_0000;
  localparam logic [31:0] PIFR_ZERO = 32'h0000_0000;

  // Value the cluster pins are taken to hold before the first sample.
  localparam logic [3:0] PIFR_CLU_RST = 4'h0;

  typedef enum logic [2:0] {
    PIFR_SEL_NONE = 3'h0,
    PIFR_SEL_TIGHT = 3'h1,
    PIFR_SEL_TLB = 3'h2,
    PIFR_SEL_AFF = 3'h3,
    PIFR_SEL_PF0 = 3'h4,
    PIFR_SEL_PF1 = 3'h5,
    PIFR_SEL_DBG = 3'h6,
    PIFR_SEL_AUX = 3'h7
  } pifr_sel_t;

endpackage

/* File: core/pifr_pin_sync.sv */
`timescale 1ns/1ps
module pifr_pin_sync
  import pifr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Pin side
  input wire logic [PIFR_CLU_W-1:0] i_pins,
  // Filtered value
  output logic [PIFR_CLU_W-1:0] o_value
);

  logic [PIFR_CLU_W-1:0] s1_q;
  logic [PIFR_CLU_W-1:0] s2_q;
  logic [PIFR_CLU_W-1:0] s3_q;
  logic [PIFR_CLU_W-1:0] val_q;
  logic [PIFR_CLU_W-1:0] val_d;

  // The first stage feeds only the second, so no gate sees a metastable bit.
  assign val_d = (s2_q == s3_q) ? s3_q : val_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= PIFR_CLU_RST;
      s2_q <= PIFR_CLU_RST;
      s3_q <= PIFR_CLU_RST;
      val_q <= PIFR_CLU_RST;
    end else begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      val_q <= val_d;
    end
  end

  assign o_value = val_q;

endmodule

/* File: core/pifr_regs.sv */
`timescale 1ns/1ps
module pifr_regs
  import pifr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Coprocessor access port
  input wire logic i_cp_valid,
  input wire logic i_cp_write,
  input wire logic [3:0] i_cp_num,
  input wire logic [2:0] i_cp_opc1,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_crm,
  input wire logic [2:0] i_cp_opc2,
  input wire logic i_cp_priv,
  // Configuration pins
  input wire logic [PIFR_CLU_W-1:0] i_cluster_identifier_pins,
  // Answer
  output logic o_cp_ack,
  output logic o_cp_undef,
  output logic [31:0] o_cp_rdata
);

  // Decoding of the opcode fields into a register selection.
  function automatic pifr_sel_t pifr_decode(
    input logic [3:0] num,
    input logic [2:0] opc1,
    input logic [3:0] crn,
    input logic [3:0] crm,
    input logic [2:0] opc2
  );
    pifr_sel_t sel;
    sel = PIFR_SEL_NONE;
    if (num == PIFR_CP_NUM && opc1 == PIFR_OPC1 && crn == PIFR_CRN) begin
      if (crm == PIFR_CRM_ID) begin
        unique case (opc2)
          PIFR_OPC2_TIGHT: sel = PIFR_SEL_TIGHT;
          PIFR_OPC2_TLB: sel = PIFR_SEL_TLB;
          PIFR_OPC2_AFF: sel = PIFR_SEL_AFF;
          default: sel = PIFR_SEL_NONE;
        endcase
      end else if (crm == PIFR_CRM_FEAT) begin
        unique case (opc2)
          PIFR_OPC2_PF0: sel = PIFR_SEL_PF0;
          PIFR_OPC2_PF1: sel = PIFR_SEL_PF1;
          PIFR_OPC2_DBG: sel = PIFR_SEL_DBG;
          PIFR_OPC2_AUX: sel = PIFR_SEL_AUX;
          default: sel = PIFR_SEL_NONE;
        endcase
      end
    end
    return sel;
  endfunction

  logic [PIFR_CLU_W-1:0] cluster_value;
  pifr_sel_t sel;
  logic [31:0] affinity_word;
  logic [31:0] read_word;
  logic mapped;
  logic write_ok;
  logic refuse;
  logic ack_q;
  logic ack_d;
  logic undef_q;
  logic undef_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Pins come from outside the clock domain and are filtered before use.
  pifr_pin_sync u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_cluster_identifier_pins),
    .o_value(cluster_value)
  );

  assign sel = pifr_decode(i_cp_num, i_cp_opc1, i_cp_crn, i_cp_crm,
                           i_cp_opc2);
  assign mapped = (sel != PIFR_SEL_NONE);

  // The bank is read-only; only the auxiliary register swallows a write.
  assign write_ok = !i_cp_write || (sel == PIFR_SEL_AUX);

  // There is no security input: both worlds see one copy of each value.
  assign refuse = !i_cp_priv || !mapped || !write_ok;

  always_comb begin
    affinity_word = PIFR_ZERO;
    affinity_word[PIFR_AFF_FMT_BIT] = 1'b1;
    affinity_word[PIFR_AFF_UNI_BIT] = 1'b1;
    affinity_word[PIFR_AFF_CLU_LSB +: PIFR_CLU_W] = cluster_value;
    affinity_word[1:0] = PIFR_CORE_NUMBER;
  end

  assign read_word =
    (sel == PIFR_SEL_TIGHT) ? PIFR_ZERO :
    (sel == PIFR_SEL_TLB) ? PIFR_ZERO :
    (sel == PIFR_SEL_AFF) ? affinity_word :
    (sel == PIFR_SEL_PF0) ? PIFR_PF0_VAL :
    (sel == PIFR_SEL_PF1) ? PIFR_PF1_VAL :
    (sel == PIFR_SEL_DBG) ? PIFR_DBG_VAL :
    PIFR_AUX_VAL;

  // Refused or write accesses return zero so no value leaks to user mode.
  assign ack_d = i_cp_valid;
  assign undef_d = i_cp_valid && refuse;
  assign rdata_d = (i_cp_valid && !refuse && !i_cp_write) ? read_word
                                                          : PIFR_ZERO;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      undef_q <= 1'b0;
      rdata_q <= PIFR_ZERO;
    end else begin
      ack_q <= ack_d;
      undef_q <= undef_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_cp_ack = ack_q;
  assign o_cp_undef = undef_q;
  assign o_cp_rdata = rdata_q;

endmodule

/* File: testbench/pifr_regs_asserts.sv */
`timescale 1ns/1ps
module pifr_regs_chk
  import pifr_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Access port
  input wire logic i_cp_valid,
  input wire logic i_cp_write,
  input wire logic [3:0] i_cp_num,
  input wire logic [2:0] i_cp_opc1,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_crm,
  input wire logic [2:0] i_cp_opc2,
  input wire logic i_cp_priv,
  input wire logic [PIFR_CLU_W-1:0] i_cluster_identifier_pins,
  // Answer
  input wire logic o_cp_ack,
  input wire logic o_cp_undef,
  input wire logic [31:0] o_cp_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire base = i_cp_valid && i_cp_priv && i_cp_num == 4'hf &&
    i_cp_opc1 == 3'h0 && i_cp_crn == 4'h0;
  wire g0 = base && !i_cp_write && i_cp_crm == 4'h0;
  wire g1 = base && !i_cp_write && i_cp_crm == 4'h1;
  wire aff = g0 && i_cp_opc2 == 3'h5;
  wire [31:0] d = o_cp_rdata;
  wire zok = o_cp_ack && !o_cp_undef && d == 32'h0000_0000;
  a_ack_one_cycle:
    assert property (i_cp_valid |=> o_cp_ack) else $error("ack missing");
  a_id_reads_zero:
    assert property (g0 && i_cp_opc2[2:1] == 2'h1 |=> zok) else $error("id");
  a_unpriv_refused:
    assert property (i_cp_valid && !i_cp_priv |=> o_cp_undef && d == 0)
    else $error("unpriv");
  a_aff_fixed_bits:
    assert property (aff |=> !o_cp_undef && d[31:12] == 20'hc_0000 &&
    d[7:0] == 8'h00) else $error("aff bits");
  a_aff_cluster_pins:
    assert property ($stable(i_cluster_identifier_pins)[*6] ##0 aff |=>
    d[11:8] == $past(i_cluster_identifier_pins)) else $error("cluster");
  a_pf0_value:
    assert property (g1 && i_cp_opc2 == 3'h0 |=> d == 32'h0000_1231)
    else $error("pf0");
  a_pf1_value:
    assert property (g1 && i_cp_opc2 == 3'h1 |=> d == 32'h0000_0011)
    else $error("pf1");
  a_dbg_value:
    assert property (g1 && i_cp_opc2 == 3'h2 |=> d == 32'h0201_0444)
    else $error("dbg");
  a_aux_ignored:
    assert property (base && i_cp_crm == 4'h1 && i_cp_opc2 == 3'h3 |=> zok)
    else $error("aux");
  c_aff_read: cover property (aff);
  c_aux_write: cover property (base && i_cp_write && i_cp_crm == 4'h1);
  c_unpriv: cover property (i_cp_valid && !i_cp_priv);
endmodule

/* File: testbench/tb_processor_id_feature_regs.sv */
`timescale 1ns/1ps
module tb_processor_id_feature_regs;
  import pifr_pkg::*;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_cp_valid = 1'b0;
  logic i_cp_write = 1'b0, i_cp_priv = 1'b0, o_cp_ack, o_cp_undef;
  logic [3:0] i_cp_num = 4'h0, i_cp_crn = 4'h0, i_cp_crm = 4'h0;
  logic [3:0] i_cluster_identifier_pins = 4'h0;
  logic [2:0] i_cp_opc1 = 3'h0, i_cp_opc2 = 3'h0;
  logic [31:0] o_cp_rdata;
  int errors = 0, tests_run = 0, cyc = 0, seed = 61, r;
  always #2.5 i_ref_clk = ~i_ref_clk;
  pifr_regs dut (.*);
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    tests_run++;
    if (c !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Unprivileged or foreign encodings are refused before any decode.
  function automatic logic [32:0] expv();
    logic ok;
    ok = i_cp_priv && i_cp_num == 4'hf && i_cp_opc1 == 3'h0 &&
      i_cp_crn == 4'h0;
    if (ok && i_cp_crm == 4'h1 && i_cp_opc2 == 3'h3) return 33'h0;
    if (!ok || i_cp_write || i_cp_crm > 4'h1) return 33'h1_0000_0000;
    case ({i_cp_crm[0], i_cp_opc2})
      4'h2, 4'h3: return 33'h0;
      4'h5: return {3'h3, 18'h0_0000, i_cluster_identifier_pins, 8'h00};
      4'h8: return 33'h0_0000_1231;
      4'h9: return 33'h0_0000_0011;
      4'ha: return 33'h0_0201_0444;
      default: return 33'h1_0000_0000;
    endcase
  endfunction
  task automatic acc(input logic [19:0] f);
    logic [32:0] e;
    {i_cp_write, i_cp_priv, i_cp_num, i_cp_opc1, i_cp_crn, i_cp_crm,
      i_cp_opc2} = f;
    i_cp_valid = 1'b1;
    e = expv();
    @(posedge i_ref_clk);
    #1 chk(o_cp_ack === 1'b1 && {o_cp_undef, o_cp_rdata} === e, "answer");
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    r = $random(seed);
    i_cluster_identifier_pins = r[3:0];
    repeat (5) @(posedge i_ref_clk);
    #1 chk(o_cp_ack === 1'b0 && o_cp_rdata === 32'h0000_0000, "reset");
    i_rst_n = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    #1;
    for (int i = 0; i < 16; i++)
      acc({2'b01, 4'hf, 3'h0, 4'h0, 3'h0, i[3], i[2:0]});
    acc({2'b11, 4'hf, 3'h0, 4'h0, 4'h1, 3'h3});
    acc({2'b01, 4'hf, 3'h0, 4'h0, 4'h1, 3'h3});
    acc({2'b00, 4'hf, 3'h0, 4'h0, 4'h1, 3'h0});
    acc({2'b11, 4'hf, 3'h0, 4'h0, 4'h0, 3'h5});
    repeat (300) begin
      r = $random(seed);
      acc({r[1:0], r[2] ? 4'hf : r[7:4], r[3] ? 3'h0 : r[10:8],
        r[11] ? 4'h0 : r[15:12], r[16] ? {3'h0, r[17]} : r[21:18],
        r[24:22]});
    end
    repeat (4) begin
      i_cp_valid = 1'b0;
      r = $random(seed);
      i_cluster_identifier_pins = r[3:0];
      repeat (6) @(posedge i_ref_clk);
      #1 acc({2'b01, 4'hf, 3'h0, 4'h0, 4'h0, 3'h5});
    end
    i_cp_valid = 1'b0;
    @(posedge i_ref_clk);
    #1 chk(o_cp_ack === 1'b0 && o_cp_rdata === 32'h0000_0000, "idle");
    complete_run();
  end
endmodule
bind pifr_regs pifr_regs_chk u_chk (.*);
